/* File: hdl/supervisor_params.svh */
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// ********************************************************************
// Clock and timing
// ********************************************************************
`define CLK_HZ            64'd10000000
`define T_POR_MS          64'd250
`define T_LOW_MS          64'd200
`define T_WD_SEL0_MS      64'd1400
`define T_WD_SEL1_MS      64'd600
`define T_WD_SEL2_MS      64'd200
`define MS_TO_CYC(ms)     ((`CLK_HZ * (ms)) / 64'd1000)

// ********************************************************************
// Watchdog period selection field
// ********************************************************************
`define WD_SEL_HI_BIT     1
`define WD_SEL_LO_BIT     0
`define WD_SEL_1400       2'h0
`define WD_SEL_600        2'h1
`define WD_SEL_200        2'h2
`define WD_SEL_OFF        2'h3
`define WD_SEL_RESET      2'h3

`endif

/* File: hdl/supervisor_pkg.sv */
package supervisor_pkg;

    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_LOW = 2'b01,
        ST_RUN = 2'b10,
        ST_WDR = 2'b11
    } sup_state_t;

    typedef logic [1:0] wd_sel_t;

endpackage : supervisor_pkg

/* File: hdl/bus_watch_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface bus_watch_if;
    logic start_det;
    logic stop_det;
    logic wd_kick;
    logic xfer_active;
    logic abort;

    modport det (output start_det, output stop_det, output wd_kick,
                 output xfer_active, input abort);
    modport ctl (input start_det, input stop_det, input wd_kick,
                 input xfer_active, output abort);
endinterface : bus_watch_if

`default_nettype wire

/* File: hdl/bus_cond_detect.sv */
`timescale 1ns/100ps
`default_nettype none

module bus_cond_detect (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   arst_n,
    // Bus pins
    input  wire logic   scl,
    input  wire logic   sda,
    // Conditions
    bus_watch_if.det    bw
);
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       sda_prev_q;
    logic       seen_start_q;
    logic       seen_low_q;
    logic       seen_high_q;
    logic       scl_prev_q;
    logic       xfer_q;

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl};
            sda_sync_q <= {sda_sync_q[0], sda};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_prev_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= sda_sync_q[1];
            scl_prev_q <= scl_sync_q[1];
        end
    end

    // Conditions are judged only on the second stage, never on raw pins.
    assign bw.start_det = scl_sync_q[1] & sda_prev_q & ~sda_sync_q[1];
    assign bw.stop_det  = scl_sync_q[1] & ~sda_prev_q & sda_sync_q[1];

    // ****************************************************************
    // Minimal restart sequence tracking
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_start_q <= 1'b0;
            seen_low_q   <= 1'b0;
            seen_high_q  <= 1'b0;
        end else if (bw.start_det) begin
            seen_start_q <= 1'b1;
            seen_low_q   <= 1'b0;
            seen_high_q  <= 1'b0;
        end else if (bw.stop_det) begin
            seen_start_q <= 1'b0;
            seen_low_q   <= 1'b0;
            seen_high_q  <= 1'b0;
        end else begin
            if (seen_start_q && !scl_sync_q[1]) begin
                seen_low_q <= 1'b1;
            end
            if (seen_low_q && scl_sync_q[1] && !scl_prev_q) begin
                seen_high_q <= 1'b1;
            end
        end
    end

    assign bw.wd_kick = bw.stop_det & seen_high_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer_q <= 1'b0;
        end else if (bw.abort || bw.stop_det) begin
            xfer_q <= 1'b0;
        end else if (bw.start_det) begin
            xfer_q <= 1'b1;
        end
    end

    assign bw.xfer_active = xfer_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_low_after_start;
        seen_start_q && !scl_sync_q[1] && !bw.start_det && !bw.stop_det;
    endsequence

    property p_low_tracked;
        @(posedge clk) disable iff (!arst_n)
        s_low_after_start |=> seen_low_q;
    endproperty
    a_low_tracked: assert property (p_low_tracked)
        else $error("Clock low after start was not tracked.");

    property p_kick_needs_high;
        @(posedge clk) disable iff (!arst_n)
        bw.wd_kick |-> seen_start_q && seen_low_q && seen_high_q;
    endproperty
    a_kick_needs_high: assert property (p_kick_needs_high)
        else $error("Watchdog restart without full start, low, high sequence.");

    property p_start_clears_high;
        @(posedge clk) disable iff (!arst_n)
        bw.start_det |=> !seen_high_q && seen_start_q;
    endproperty
    a_start_clears_high: assert property (p_start_clears_high)
        else $error("Start condition did not restart sequence tracking.");

endmodule : bus_cond_detect

`default_nettype wire

/* File: hdl/supervisor_reset_watchdog.sv */
// Contract
// - Reset asserts whenever the supply comparator reports low supply.
// - After low supply, reset holds until the supply stays good for 200 ms without a break.
// - At power-up, reset holds for 250 ms after the supply is stable.
// - The active-high variant drives the same reset inverted, still open-drain.
// - With the watchdog enabled, reset asserts if SDA shows no valid activity for the period.
// - Any standard bus read or write sequence restarts the watchdog count.
// - Start, SCL low, SCL high and stop form the minimal accepted restart.
// - Two period bits choose the timeout and cannot change while write inhibit is high.
// - While write inhibit is high, every nonvolatile write is refused.
// - Low-supply reset aborts any bus transfer in progress.
// - During low supply, no new bus transfer or nonvolatile write may start.
// - A nonvolatile write already running at low supply is left to complete.
// - Period codes 00, 01, 10 give 1.4 s, 600 ms, 200 ms; 11 disables the watchdog.
`include "supervisor_params.svh"
`timescale 1ns/100ps
`default_nettype none

module supervisor_reset_watchdog #(
    parameter bit          ACTIVE_HIGH             = 1'b0,
    parameter int unsigned CNT_W                   = 24,
    parameter int unsigned POWER_ON_DELAY_CYC      = 32'(`MS_TO_CYC(`T_POR_MS)),
    parameter int unsigned RESET_RELEASE_DELAY_CYC = 32'(`MS_TO_CYC(`T_LOW_MS)),
    parameter int unsigned WD_1400_CYC             = 32'(`MS_TO_CYC(`T_WD_SEL0_MS)),
    parameter int unsigned WD_600_CYC              = 32'(`MS_TO_CYC(`T_WD_SEL1_MS)),
    parameter int unsigned WD_200_CYC              = 32'(`MS_TO_CYC(`T_WD_SEL2_MS))
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   arst_n,
    // Supply comparator and pins
    input  wire logic   vcc_low,
    input  wire logic   scl,
    input  wire logic   sda,
    input  wire logic   write_inhibit,
    // Watchdog period bits from the control register path
    input  wire logic   period_wr,
    input  wire logic   watchdog_period_sel_hi_in,
    input  wire logic   watchdog_period_sel_lo_in,
    output logic        watchdog_period_sel_hi,
    output logic        watchdog_period_sel_lo,
    // Nonvolatile write gating
    input  wire logic   nv_write_req,
    input  wire logic   nv_write_busy,
    output logic        nv_write_grant,
    // Bus transfer control
    output logic        bus_enable,
    output logic        bus_abort,
    // Reset pin, open drain
    output logic        rst_o,
    output logic        rst_oe
);
    import supervisor_pkg::*;

    bus_watch_if bw ();

    bus_cond_detect u_detect (
        .clk    (clk),
        .arst_n (arst_n),
        .scl    (scl),
        .sda    (sda),
        .bw     (bw)
    );

    logic [1:0]       low_sync_q;
    logic [1:0]       wp_sync_q;
    logic             low_s;
    logic             low_prev_q;
    logic             wp_s;
    wd_sel_t          wd_sel_q;
    sup_state_t       state_q;
    logic [CNT_W-1:0] hold_cnt_q;
    logic [CNT_W-1:0] hold_lim;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] wd_lim;
    logic             wd_en;
    logic             wd_fire;
    logic             bus_enable_q;
    logic             bus_abort_q;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_sync_q <= 2'h3;
            wp_sync_q  <= 2'h3;
        end else begin
            low_sync_q <= {low_sync_q[0], vcc_low};
            wp_sync_q  <= {wp_sync_q[0], write_inhibit};
        end
    end

    assign low_s = low_sync_q[1];
    assign wp_s  = wp_sync_q[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_prev_q <= 1'b1;
        end else begin
            low_prev_q <= low_s;
        end
    end

    // ****************************************************************
    // Watchdog period bits
    // ****************************************************************
    // The stored copy stands in for the nonvolatile cell; it powers up disabled.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_sel_q <= `WD_SEL_RESET;
        end else if (period_wr && !wp_s && !low_s) begin
            wd_sel_q <= {watchdog_period_sel_hi_in, watchdog_period_sel_lo_in};
        end
    end

    assign watchdog_period_sel_hi = wd_sel_q[`WD_SEL_HI_BIT];
    assign watchdog_period_sel_lo = wd_sel_q[`WD_SEL_LO_BIT];

    always_comb begin
        wd_en = 1'b1;
        case (wd_sel_q)
            `WD_SEL_1400: wd_lim = CNT_W'(WD_1400_CYC - 1);
            `WD_SEL_600:  wd_lim = CNT_W'(WD_600_CYC - 1);
            `WD_SEL_200:  wd_lim = CNT_W'(WD_200_CYC - 1);
            default: begin
                wd_lim = '0;
                wd_en  = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Watchdog counter
    // ****************************************************************
    // A stuck SDA can never form a stop, so expiry covers it as well.
    assign wd_fire = (state_q == ST_RUN) && wd_en && !bw.wd_kick && (wd_cnt_q == wd_lim);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_cnt_q <= '0;
        end else if (state_q != ST_RUN || !wd_en || bw.wd_kick || wd_fire) begin
            wd_cnt_q <= '0;
        end else begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    assign hold_lim = (state_q == ST_POR) ? CNT_W'(POWER_ON_DELAY_CYC - 1)
                                          : CNT_W'(RESET_RELEASE_DELAY_CYC - 1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= ST_POR;
            hold_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    hold_cnt_q <= '0;
                    if (low_s) begin
                        state_q <= ST_LOW;
                    end else if (wd_fire) begin
                        state_q <= ST_WDR;
                    end
                end
                ST_POR, ST_LOW, ST_WDR: begin
                    if (low_s) begin
                        hold_cnt_q <= '0;
                        if (state_q == ST_WDR) begin
                            state_q <= ST_LOW;
                        end
                    end else if (hold_cnt_q == hold_lim) begin
                        hold_cnt_q <= '0;
                        state_q    <= ST_RUN;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q    <= ST_POR;
                    hold_cnt_q <= '0;
                end
            endcase
        end
    end

    // Open drain: the pin is only ever pulled low, the pull-up does the rest.
    assign rst_o  = 1'b0;
    assign rst_oe = (state_q != ST_RUN) ^ ACTIVE_HIGH;

    // ****************************************************************
    // Bus and write gating
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_enable_q <= 1'b0;
            bus_abort_q  <= 1'b0;
        end else begin
            bus_enable_q <= !low_s;
            bus_abort_q  <= low_s && !low_prev_q && bw.xfer_active;
        end
    end

    assign bw.abort   = bus_abort_q;
    assign bus_enable = bus_enable_q;
    assign bus_abort  = bus_abort_q;

    // Only the start of a write is gated; nv_write_busy is never cut short.
    assign nv_write_grant = nv_write_req && !nv_write_busy && !wp_s && !low_s;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_supply_drop;
        low_s && !low_prev_q;
    endsequence

    sequence s_hold_done;
        !low_s && (hold_cnt_q == hold_lim);
    endsequence

    property p_low_asserts;
        @(posedge clk) disable iff (!arst_n)
        low_s |=> (state_q == ST_LOW || state_q == ST_POR);
    endproperty
    a_low_asserts: assert property (p_low_asserts)
        else $error("Low supply did not hold reset.");

    property p_low_release;
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_LOW) ##0 s_hold_done |=> (state_q == ST_RUN);
    endproperty
    a_low_release: assert property (p_low_release)
        else $error("Reset not released after low supply hold.");

    property p_low_no_early;
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_LOW) && low_s |=> (state_q != ST_RUN);
    endproperty
    a_low_no_early: assert property (p_low_no_early)
        else $error("Reset released while supply was still low.");

    property p_run_needs_count;
        @(posedge clk) disable iff (!arst_n)
        (state_q != ST_RUN) ##1 (state_q == ST_RUN)
            |-> $past(hold_cnt_q) == $past(hold_lim);
    endproperty
    a_run_needs_count: assert property (p_run_needs_count)
        else $error("Reset released before its hold count ended.");

    property p_por_limit;
        @(posedge clk) disable iff (!arst_n)
        $fell(state_q == ST_POR)
            |-> (state_q == ST_RUN) && ($past(hold_cnt_q) == CNT_W'(POWER_ON_DELAY_CYC - 1));
    endproperty
    a_por_limit: assert property (p_por_limit)
        else $error("Power-on hold uses the wrong length.");

    property p_polarity;
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_RUN) |-> (rst_oe == ACTIVE_HIGH) && !rst_o;
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("Reset pin drive does not match variant when idle.");

    property p_wd_fire;
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_RUN) && !low_s && wd_en && !bw.wd_kick && (wd_cnt_q == wd_lim)
            |=> (state_q == ST_WDR) && !rst_oe == ACTIVE_HIGH;
    endproperty
    a_wd_fire: assert property (p_wd_fire)
        else $error("Watchdog expiry did not assert reset.");

    property p_kick_clears;
        @(posedge clk) disable iff (!arst_n)
        bw.wd_kick && (state_q == ST_RUN) |=> (wd_cnt_q == '0) && (state_q != ST_WDR);
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("Bus sequence did not restart the watchdog.");

    property p_wp_lock;
        @(posedge clk) disable iff (!arst_n)
        wp_s |=> $stable(wd_sel_q);
    endproperty
    a_wp_lock: assert property (p_wp_lock)
        else $error("Period bits changed while write inhibit was high.");

    property p_wp_reject;
        @(posedge clk) disable iff (!arst_n)
        wp_s |-> !nv_write_grant;
    endproperty
    a_wp_reject: assert property (p_wp_reject)
        else $error("Write granted while write inhibit was high.");

    property p_abort;
        @(posedge clk) disable iff (!arst_n)
        s_supply_drop ##0 bw.xfer_active |=> bus_abort ##1 !bw.xfer_active;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Transfer not aborted on low supply.");

    property p_no_new;
        @(posedge clk) disable iff (!arst_n)
        low_s |-> !nv_write_grant ##1 !bus_enable;
    endproperty
    a_no_new: assert property (p_no_new)
        else $error("New transfer or write allowed during low supply.");

    property p_wd_off;
        @(posedge clk) disable iff (!arst_n)
        (wd_sel_q == `WD_SEL_OFF) |=> (wd_cnt_q == '0);
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("Watchdog counted while disabled.");

endmodule : supervisor_reset_watchdog

`default_nettype wire

/* File: test/host_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Host side of the two-wire bus
// ****************************************************************
// Both lines idle high, as the pull-ups would leave them.
module host_bus_model (
    // Clock
    input  wire logic clk,
    // Bus lines
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Each phase lasts two cycles so the synchronised samples see it.
    task automatic step(input logic c, input logic d);
        repeat (2) @(posedge clk);
        #10;
        scl = c;
        sda = d;
    endtask : step

    // Start, clock low, clock high and stop: the shortest restart.
    task automatic kick();
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : kick

    task automatic open_xfer();
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : open_xfer

    task automatic release_bus();
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : release_bus
endmodule : host_bus_model

`default_nettype wire

/* File: test/supervisor_reset_watchdog_test.sv */
`timescale 1ns/100ps
`default_nettype none

module supervisor_reset_watchdog_test;
    import supervisor_pkg::*;

    // ****************************************************************
    // Shortened counts and bench state
    // ****************************************************************
    localparam int unsigned POR_C     = 20;
    localparam int unsigned REL_C     = 16;
    localparam int unsigned WD_C [3]  = '{240, 120, 60};
    // Active-low variant: the pin is pulled while reset is asserted.
    localparam logic        ON        = 1'b1;

    logic        clk;
    logic        arst_n;
    logic        vcc_low;
    logic        write_inhibit;
    logic        period_wr;
    logic [1:0]  sel;
    logic        nv_write_req;
    logic        nv_write_busy;
    wire         scl;
    wire         sda;
    logic        sel_hi;
    logic        sel_lo;
    logic        nv_write_grant;
    logic        bus_enable;
    logic        bus_abort;
    logic        rst_o;
    logic        rst_oe;
    logic        rst_oe_h;
    logic        prev_oe;
    int          failures;
    int          n_tests;
    int          cyc;
    int          n_abort;
    int          t;
    logic        exp_val [$];
    int          exp_at [$];

    supervisor_reset_watchdog #(
        .POWER_ON_DELAY_CYC      (POR_C),
        .RESET_RELEASE_DELAY_CYC (REL_C),
        .WD_1400_CYC             (WD_C[0]),
        .WD_600_CYC              (WD_C[1]),
        .WD_200_CYC              (WD_C[2])
    ) DUT (
        .clk                       (clk),
        .arst_n                    (arst_n),
        .vcc_low                   (vcc_low),
        .scl                       (scl),
        .sda                       (sda),
        .write_inhibit             (write_inhibit),
        .period_wr                 (period_wr),
        .watchdog_period_sel_hi_in (sel[1]),
        .watchdog_period_sel_lo_in (sel[0]),
        .watchdog_period_sel_hi    (sel_hi),
        .watchdog_period_sel_lo    (sel_lo),
        .nv_write_req              (nv_write_req),
        .nv_write_busy             (nv_write_busy),
        .nv_write_grant            (nv_write_grant),
        .bus_enable                (bus_enable),
        .bus_abort                 (bus_abort),
        .rst_o                     (rst_o),
        .rst_oe                    (rst_oe)
    );

    supervisor_reset_watchdog #(
        .ACTIVE_HIGH             (1'b1),
        .POWER_ON_DELAY_CYC      (POR_C),
        .RESET_RELEASE_DELAY_CYC (REL_C),
        .WD_1400_CYC             (WD_C[0]),
        .WD_600_CYC              (WD_C[1]),
        .WD_200_CYC              (WD_C[2])
    ) DUT_H (
        .clk                       (clk),
        .arst_n                    (arst_n),
        .vcc_low                   (vcc_low),
        .scl                       (scl),
        .sda                       (sda),
        .write_inhibit             (write_inhibit),
        .period_wr                 (period_wr),
        .watchdog_period_sel_hi_in (sel[1]),
        .watchdog_period_sel_lo_in (sel[0]),
        .watchdog_period_sel_hi    (),
        .watchdog_period_sel_lo    (),
        .nv_write_req              (nv_write_req),
        .nv_write_busy             (nv_write_busy),
        .nv_write_grant            (),
        .bus_enable                (),
        .bus_abort                 (),
        .rst_o                     (),
        .rst_oe                    (rst_oe_h)
    );

    host_bus_model host (
        .clk (clk),
        .scl (scl),
        .sda (sda)
    );

    always #50 clk = ~clk;

    always @(posedge clk) cyc <= cyc + 1;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic fail(input string m);
        failures++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail

    task automatic check_lvl(input logic got, input logic want, input string what);
        n_tests++;
        if (got !== want) fail($sformatf("%s is %b, expected %b", what, got, want));
    endtask : check_lvl

    // Edge timing is allowed three cycles of slack for the synchronisers.
    task automatic check_evt(input logic got, input logic want, input int at);
        n_tests++;
        if (got !== want || cyc > at + 3 || cyc + 3 < at) begin
            fail($sformatf("reset pin %b at cycle %0d, expected %b near %0d",
                           got, cyc, want, at));
        end
    endtask : check_evt

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    task automatic expect_rst(input logic v, input int at);
        exp_val.push_back(v);
        exp_at.push_back(at);
    endtask : expect_rst

    task automatic await_events(input int lim);
        for (int i = 0; i < lim && exp_at.size() != 0; i++) tick(1);
        if (exp_at.size() != 0) begin
            fail("reset pin did not move in time");
            exp_at.delete();
            exp_val.delete();
        end
    endtask : await_events

    task automatic write_period(input logic [1:0] v);
        sel = v;
        period_wr = 1'b1;
        tick(1);
        period_wr = 1'b0;
    endtask : write_period

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // Output watcher
    // ****************************************************************
    always @(negedge clk) begin
        if (arst_n === 1'b1) begin
            if (bus_abort === 1'b1) n_abort++;
            check_lvl(rst_oe_h, ~rst_oe, "active-high variant pin");
            if (rst_oe !== prev_oe) begin
                if (exp_at.size() == 0) fail("reset pin moved unexpectedly");
                else check_evt(rst_oe, exp_val.pop_front(), exp_at.pop_front());
                prev_oe = rst_oe;
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail("run did not finish in time");
        give_verdict();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        vcc_low = 1'b0;
        write_inhibit = 1'b0;
        period_wr = 1'b0;
        sel = 2'h0;
        nv_write_req = 1'b0;
        nv_write_busy = 1'b0;
        failures = 0;
        n_tests = 0;
        cyc = 0;
        n_abort = 0;
        prev_oe = ON;
        void'($urandom(32'h7066));
        tick(5);
        arst_n = 1'b1;
        expect_rst(~ON, cyc + POR_C + 2);
        await_events(POR_C + 20);
        check_lvl(sel_hi, 1'b1, "period bit high");
        check_lvl(sel_lo, 1'b1, "period bit low");
        check_lvl(rst_o, 1'b0, "reset drive level");
        $display("test power_on done");

        write_inhibit = 1'b1;
        tick(3);
        write_period(2'($urandom_range(2)));
        check_lvl(sel_hi & sel_lo, 1'b1, "locked period bits");
        nv_write_req = 1'b1;
        tick(1);
        check_lvl(nv_write_grant, 1'b0, "grant while inhibited");
        write_inhibit = 1'b0;
        tick(3);
        check_lvl(nv_write_grant, 1'b1, "grant when free");
        nv_write_busy = 1'b1;
        tick(1);
        check_lvl(nv_write_grant, 1'b0, "grant while busy");
        nv_write_busy = 1'b0;
        $display("test write_inhibit done");

        host.open_xfer();
        vcc_low = 1'b1;
        expect_rst(ON, cyc + 3);
        tick(4 + $urandom_range(7));
        check_lvl(bus_enable, 1'b0, "bus enable in low supply");
        check_lvl(nv_write_grant, 1'b0, "grant in low supply");
        check_lvl(n_abort == 1, 1'b1, "one abort pulse");
        write_period(2'h2);
        check_lvl(sel_hi & sel_lo, 1'b1, "period bits in low supply");
        host.release_bus();
        vcc_low = 1'b0;
        tick(5);
        vcc_low = 1'b1;
        tick(3);
        vcc_low = 1'b0;
        expect_rst(~ON, cyc + REL_C + 2);
        await_events(REL_C + 30);
        check_lvl(bus_enable, 1'b1, "bus enable after recovery");
        nv_write_req = 1'b0;
        $display("test low_supply done");

        for (int c = 0; c < 3; c++) begin
            write_period(2'(c));
            check_lvl(sel_hi, c[1], "stored period bit high");
            check_lvl(sel_lo, c[0], "stored period bit low");
            repeat (4) begin
                host.kick();
                t = cyc;
                tick(WD_C[c] / 2);
            end
            expect_rst(ON, t + WD_C[c] + 4);
            expect_rst(~ON, t + WD_C[c] + 4 + REL_C);
            await_events(WD_C[c] + 60);
            $display("test watchdog code %0d done", c);
        end
        write_period(2'h3);
        tick(300);
        check_lvl(rst_oe, ~ON, "reset idle with watchdog off");
        $display("test watchdog_off done");
        give_verdict();
    end
endmodule : supervisor_reset_watchdog_test

`default_nettype wire
